//--- design/bdp_defs.vh
/*
 Constants for the bulk data port: mode field codes, format codes,
 pacing figures and widths of the synchronised input vector.
 Assumes inclusion by bare name from the design files.
*/
`ifndef BDP_DEFS_VH
`define BDP_DEFS_VH

// Input mode field codes (3 bits)
`define BDP_IMODE_AB 3'h0
`define BDP_IMODE_C 3'h5
`define BDP_IMODE_D 3'h1

// Output mode field codes (2 bits)
`define BDP_OMODE_A 2'h0
`define BDP_OMODE_B 2'h1
`define BDP_OMODE_C 2'h3
`define BDP_OMODE_D 2'h0

// Format codes on the format buses
`define BDP_FMT_START 3'h5
`define BDP_FMT_CONT 3'h1
`define BDP_FMT_IDLE 3'h4
`define BDP_FMT_START_BIT 2

// Paced mode: one transfer per this many half-rate clock cycles
`define BDP_PACE_CYCLES 3'h4
`define BDP_PACE_LAST 2'h3

// Bytes in a quadlet, last byte index
`define BDP_QUAD_LAST 2'h3

// Synchronised pin vector layout
`define BDP_SYNC_W 21
`define BDP_S_DATA_LO 0
`define BDP_S_FMT_LO 8
`define BDP_S_EN 11
`define BDP_S_DIR 12
`define BDP_S_ICLK 13
`define BDP_S_OCLK 14
`define BDP_S_HALF_RATE_SYS_CLOCK 15
`define BDP_S_IMODE_LO 16
`define BDP_S_OMODE_LO 19

`endif

//--- design/bdp_sync.v
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes each bit is a level from outside the i_mclk domain; bits are
 not guaranteed coherent with each other on the same edge.
*/
`timescale 1ns/10ps
module bdp_sync
#(
   parameter W = 21
)
(
   input wire i_mclk,
   input wire i_resetn,
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // One pair of flops per bit
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         always @(posedge i_mclk or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end
            else
            begin
               meta_q[g] <= i_async[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign o_sync = sync_q;

endmodule // bdp_sync

//--- design/bdp_port.v
/*
 Bulk data port: byte-wide host port between the host application and
 the transmit and receive FIFOs of the link controller, modes A to D.
 Assumes FIFO side signals are on i_mclk; all pins, including the port
 clocks and the half-rate clock, are asynchronous and are synchronised
 here. Port clocks must be much slower than i_mclk (about 8 cycles
 high and low at least). i_rx_valid must settle one cycle after a pop.
*/
`timescale 1ns/10ps
`include "bdp_defs.vh"

// Summary of operation
// - Paced mode accepts host writes only once every four half-rate cycles.
// - Paced mode carries cells only; top format bit marks a cell start.
// - Unidirectional modes show each output byte format, same encoding.
// - Mode B drives received bytes out without any host request.
// - Data-available follows the receive holding register being loaded.
// - Paced mode reads happen at most once every four half-rate cycles.
// - Only mode D shares one byte bus and format lines both ways.
// - Format 101 marks packet start, 001 following byte, 100 idle.
// - Mode D: enable qualifies, direction high reads, low writes.
// - Mode D: busy is asserted while the transmit FIFO is full.
// - Mode D: writes on input port clock, reads on output port clock.
// - Mode D read drives data byte and format on shared lines.
// - Mode D reads and writes may alternate on consecutive cycles.
// - While busy, writes stop but reads continue at full rate.
// - Enable low in mode D stops transfers and releases shared buses.
// - Mode D asserts data-available while a packet is in receive FIFO.
// - Mode pairs 000/00, 000/01, 101/11, 001/00 select modes A to D.
// - Unidirectional busy changes on quadlet boundaries; refuses input.
// - Paced mode has no busy indication.
module bdp_port
(
   input wire i_mclk,
   input wire i_resetn,
   // Host pins
   input wire [7:0] i_bulk_io_bus,
   output wire [7:0] o_bulk_io_bus,
   output wire o_bulk_io_bus_oe,
   input wire [2:0] i_input_format_bus,
   output wire [2:0] o_input_format_bus,
   output wire o_input_format_bus_oe,
   output wire [7:0] o_bulk_out_bus,
   output wire [2:0] o_output_format_bus,
   input wire i_input_enable,
   input wire i_output_enable_dir_sel,
   output wire o_input_busy,
   output wire o_output_data_avail,
   input wire i_input_port_clock,
   input wire i_output_port_clock,
   input wire i_half_rate_sys_clock,
   input wire [2:0] i_input_mode_field,
   input wire [1:0] i_output_mode_field,
   // Transmit FIFO write side
   output wire [7:0] o_tx_data,
   output wire [2:0] o_tx_fmt,
   output wire o_tx_push,
   input wire i_tx_full,
   // Receive FIFO read side
   input wire [7:0] i_rx_data,
   input wire [2:0] i_rx_fmt,
   input wire i_rx_valid,
   input wire i_rx_hold_loaded,
   output wire o_rx_pop
);

   wire [`BDP_SYNC_W-1:0] pins_async, pins;
   wire [7:0] s_data;
   wire [2:0] s_fmt, s_clks, s_imode;
   wire s_en, s_dir;
   wire [1:0] s_omode;
   reg [2:0] clk_d_q;
   wire in_rise, out_rise, n_rise;
   wire mode_a, mode_b, mode_c, mode_d, mode_ok;
   reg [1:0] in_phase_q, out_phase_q;
   reg in_armed_q, out_armed_q;
   reg [1:0] quad_cnt_q;
   reg busy_q, avail_q;
   reg wr_take, rd_take;
   reg [2:0] wr_fmt;
   reg [7:0] tx_data_q;
   reg [2:0] tx_fmt_q;
   reg tx_push_q, rx_pop_q;
   reg [7:0] out_bus_q, io_bus_q;
   reg [2:0] out_fmt_q, io_fmt_q;
   reg io_oe_q, fmt_oe_q;

   // Every host pin passes two flops before use
   assign pins_async = {i_output_mode_field, i_input_mode_field,
                        i_half_rate_sys_clock, i_output_port_clock,
                        i_input_port_clock, i_output_enable_dir_sel,
                        i_input_enable, i_input_format_bus,
                        i_bulk_io_bus};

   bdp_sync #(.W(`BDP_SYNC_W)) u_sync
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_async(pins_async),
      .o_sync(pins)
   );

   // Slices of the synchronised vector
   assign s_data = pins[`BDP_S_DATA_LO +: 8];
   assign s_fmt = pins[`BDP_S_FMT_LO +: 3];
   assign s_en = pins[`BDP_S_EN];
   assign s_dir = pins[`BDP_S_DIR];
   assign s_clks = pins[`BDP_S_ICLK +: 3];
   assign s_imode = pins[`BDP_S_IMODE_LO +: 3];
   assign s_omode = pins[`BDP_S_OMODE_LO +: 2];

   // Mode decode from the field pair
   assign mode_a = (s_imode == `BDP_IMODE_AB) &&
                   (s_omode == `BDP_OMODE_A);
   assign mode_b = (s_imode == `BDP_IMODE_AB) &&
                   (s_omode == `BDP_OMODE_B);
   assign mode_c = (s_imode == `BDP_IMODE_C) &&
                   (s_omode == `BDP_OMODE_C);
   assign mode_d = (s_imode == `BDP_IMODE_D) &&
                   (s_omode == `BDP_OMODE_D);
   assign mode_ok = mode_a | mode_b | mode_c | mode_d;

   // Rising edges of the sampled port clocks
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         clk_d_q <= 3'h0;
      else
         clk_d_q <= s_clks;
   end

   assign in_rise = s_clks[0] & ~clk_d_q[0];
   assign out_rise = s_clks[1] & ~clk_d_q[1];
   assign n_rise = s_clks[2] & ~clk_d_q[2];

   // Paced mode phase counters and idle-gap arming
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         in_phase_q <= 2'h0;
         out_phase_q <= 2'h0;
         in_armed_q <= 1'b0;
         out_armed_q <= 1'b0;
      end
      else if (!mode_c)
      begin
         in_phase_q <= 2'h0;
         out_phase_q <= 2'h0;
         in_armed_q <= 1'b0;
         out_armed_q <= 1'b0;
      end
      else if (n_rise)
      begin
         // Free-running quarter counters on the half-rate clock
         in_phase_q <= in_phase_q + 2'h1;
         out_phase_q <= out_phase_q + 2'h1;
         // A gap with enable low arms the next transfer
         if (!s_en)
            in_armed_q <= 1'b1;
         else if (wr_take)
            in_armed_q <= 1'b0;
         if (!s_dir)
            out_armed_q <= 1'b1;
         else if (rd_take)
            out_armed_q <= 1'b0;
      end
   end

   // Write acceptance per mode
   always @*
   begin
      wr_take = 1'b0;
      wr_fmt = s_fmt;
      if (mode_a || mode_b)
         wr_take = in_rise & s_en & ~busy_q;
      else if (mode_d)
         wr_take = in_rise & s_en & ~s_dir & ~busy_q;
      else if (mode_c)
      begin
         wr_take = n_rise & (in_phase_q == 2'h0) & s_en &
                   in_armed_q;
         // Only the top format bit is looked at
         if (s_fmt[`BDP_FMT_START_BIT])
            wr_fmt = `BDP_FMT_START;
         else
            wr_fmt = `BDP_FMT_CONT;
      end
   end

   // Read acceptance per mode
   always @*
   begin
      rd_take = 1'b0;
      if (mode_a)
         rd_take = out_rise & s_dir & i_rx_valid;
      else if (mode_b)
         rd_take = out_rise & i_rx_valid;
      else if (mode_c)
         rd_take = n_rise & (out_phase_q == 2'h0) & s_dir &
                   out_armed_q & i_rx_valid;
      else if (mode_d)
         rd_take = out_rise & s_en & s_dir & i_rx_valid;
   end

   // Transmit FIFO push
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tx_data_q <= 8'h00;
         tx_fmt_q <= `BDP_FMT_IDLE;
         tx_push_q <= 1'b0;
      end
      else
      begin
         tx_push_q <= wr_take;
         if (wr_take)
         begin
            tx_data_q <= s_data;
            tx_fmt_q <= wr_fmt;
         end
      end
   end

   // Busy: quadlet-aligned in A/B, direct in D, none in C
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         busy_q <= 1'b0;
         quad_cnt_q <= 2'h0;
      end
      else if (mode_a || mode_b)
      begin
         if (wr_take)
            quad_cnt_q <= quad_cnt_q + 2'h1;
         // Re-evaluated only ahead of a quadlet's first byte
         if (in_rise && (quad_cnt_q == 2'h0))
            busy_q <= i_tx_full;
      end
      else if (mode_d)
      begin
         quad_cnt_q <= 2'h0;
         busy_q <= i_tx_full;
      end
      else
      begin
         quad_cnt_q <= 2'h0;
         busy_q <= 1'b0;
      end
   end

   // Data available follows the loaded holding register
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         avail_q <= 1'b0;
      else
         avail_q <= mode_ok & i_rx_hold_loaded;
   end

   // Separate output bus for modes A, B and C
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         out_bus_q <= 8'h00;
         out_fmt_q <= `BDP_FMT_IDLE;
      end
      else if (mode_a || mode_b || mode_c)
      begin
         if (rd_take)
         begin
            out_bus_q <= i_rx_data;
            out_fmt_q <= i_rx_fmt;
         end
         else if (out_rise && !mode_c)
            out_fmt_q <= `BDP_FMT_IDLE;
      end
      else
         out_fmt_q <= `BDP_FMT_IDLE;
   end

   // Shared bus drive in mode D
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         io_bus_q <= 8'h00;
         io_fmt_q <= `BDP_FMT_IDLE;
         io_oe_q <= 1'b0;
         fmt_oe_q <= 1'b0;
      end
      else
      begin
         // Drive only while enabled and reading, else released
         io_oe_q <= mode_d & s_en & s_dir;
         fmt_oe_q <= mode_d & s_en & s_dir;
         if (mode_d && rd_take)
         begin
            io_bus_q <= i_rx_data;
            io_fmt_q <= i_rx_fmt;
         end
      end
   end

   // Receive FIFO pop, one cycle per byte taken
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         rx_pop_q <= 1'b0;
      else
         rx_pop_q <= rd_take;
   end

   // Outputs straight from flops
   assign o_bulk_io_bus = io_bus_q;
   assign o_bulk_io_bus_oe = io_oe_q;
   assign o_input_format_bus = io_fmt_q;
   assign o_input_format_bus_oe = fmt_oe_q;
   assign o_bulk_out_bus = out_bus_q;
   assign o_output_format_bus = out_fmt_q;
   assign o_input_busy = busy_q;
   assign o_output_data_avail = avail_q;
   assign o_tx_data = tx_data_q;
   assign o_tx_fmt = tx_fmt_q;
   assign o_tx_push = tx_push_q;
   assign o_rx_pop = rx_pop_q;

endmodule // bdp_port

//--- dv/bdp_port_asserts.sv
/* Checker for bdp_port: timing relations seen at its ports.
   Assumes bdp_defs.vh and one system clock domain. */
`timescale 1ns/10ps
`include "bdp_defs.vh"
module bdp_chk
(
   input wire i_mclk,
   input wire i_resetn,
   input wire i_input_enable,
   input wire i_output_enable_dir_sel,
   input wire [2:0] i_input_mode_field,
   input wire [1:0] i_output_mode_field,
   input wire i_tx_full,
   input wire [7:0] i_rx_data,
   input wire [2:0] i_rx_fmt,
   input wire i_rx_hold_loaded,
   input wire [7:0] o_bulk_io_bus,
   input wire o_bulk_io_bus_oe,
   input wire [2:0] o_input_format_bus,
   input wire o_input_format_bus_oe,
   input wire [2:0] o_output_format_bus,
   input wire o_input_busy,
   input wire o_output_data_avail,
   input wire o_tx_push,
   input wire o_rx_pop
);
   // Mode decodes straight from the pins
   wire [4:0] md = {i_input_mode_field, i_output_mode_field};
   wire c_m = md == {`BDP_IMODE_C, `BDP_OMODE_C};
   wire d_m = md == {`BDP_IMODE_D, `BDP_OMODE_D};
   wire d_rd = d_m && i_input_enable && i_output_enable_dir_sel;
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   // Shared-bus read, and a run of idle enable
   sequence s_dread;
      o_rx_pop && o_bulk_io_bus_oe;
   endsequence
   sequence s_idle;
      !i_input_enable [*4];
   endsequence
   AST_RST_IDLE:
   assert property ($rose(i_resetn) |-> !o_bulk_io_bus_oe && !o_input_busy
      && !o_output_data_avail && o_output_format_bus == `BDP_FMT_IDLE)
      else $error("not idle after reset");
   AST_OE_PAIR:
   assert property (o_bulk_io_bus_oe == o_input_format_bus_oe)
      else $error("oe pair differs");
   AST_OE_CAUSE:
   assert property (o_bulk_io_bus_oe |-> $past(d_rd, 3))
      else $error("drive without read");
   AST_RELEASE:
   assert property (s_idle |-> !o_bulk_io_bus_oe)
      else $error("bus not released");
   AST_D_READ:
   assert property (s_dread |-> o_bulk_io_bus == $past(i_rx_data)
      && o_input_format_bus == $past(i_rx_fmt))
      else $error("read byte wrong");
   AST_PUSH_FREE:
   assert property (o_tx_push |-> !$past(o_input_busy))
      else $error("write taken while busy");
   AST_D_BUSY:
   assert property (d_m [*5] |-> o_input_busy == $past(i_tx_full))
      else $error("busy not tracking full");
   AST_C_NOBUSY:
   assert property (c_m [*5] |-> !o_input_busy)
      else $error("busy in paced mode");
   AST_AVAIL:
   assert property (o_output_data_avail |-> $past(i_rx_hold_loaded))
      else $error("avail without data");
   AST_PACE:
   assert property (c_m && o_tx_push |=> !o_tx_push [*8])
      else $error("paced writes too close");
   AST_POP_PULSE:
   assert property (o_rx_pop |=> !o_rx_pop)
      else $error("pop longer than a cycle");
endmodule // bdp_chk

bind bdp_port bdp_chk u_chk (.i_mclk, .i_resetn, .i_input_enable,
   .i_output_enable_dir_sel, .i_input_mode_field, .i_output_mode_field,
   .i_tx_full, .i_rx_data, .i_rx_fmt, .i_rx_hold_loaded, .o_bulk_io_bus,
   .o_bulk_io_bus_oe, .o_input_format_bus, .o_input_format_bus_oe,
   .o_output_format_bus, .o_input_busy, .o_output_data_avail, .o_tx_push,
   .o_rx_pop);

//--- dv/bdp_fifo_model.sv
/* Link FIFO model: transmit sink and receive source.
   Assumes the bench loads rxq and raises i_stall to fill the sink. */
`timescale 1ns/10ps
module bdp_fifo_model
(
   input wire i_mclk,
   input wire [7:0] i_tx_data,
   input wire [2:0] i_tx_fmt,
   input wire i_tx_push,
   input wire i_stall,
   output logic o_tx_full,
   output logic [7:0] o_rx_data,
   output logic [2:0] o_rx_fmt,
   output logic o_rx_valid,
   input wire i_rx_pop
);
   logic [10:0] rxq[$];
   logic [10:0] last_tx = 11'h0;
   logic [10:0] npush = 11'h0;
   logic [10:0] npop = 11'h0;
   initial
   begin
      o_tx_full = 1'b0;
      o_rx_valid = 1'b0;
      {o_rx_fmt, o_rx_data} = 11'h0;
   end
   // Sink pushes; pop the head, show the next one a cycle later
   always @(posedge i_mclk)
   begin
      o_tx_full <= i_stall;
      if (i_tx_push)
      begin
         npush <= npush + 11'h1;
         last_tx <= {i_tx_fmt, i_tx_data};
      end
      if (i_rx_pop && rxq.size() > 0)
      begin
         npop <= npop + 11'h1;
         void'(rxq.pop_front());
      end
      o_rx_valid <= rxq.size() > 0;
      // Empty head toggles so stale data never looks valid
      {o_rx_fmt, o_rx_data} <= rxq.size() > 0 ? rxq[0]
         : ~{o_rx_fmt, o_rx_data};
   end
endmodule // bdp_fifo_model

//--- dv/tb.sv
/* Bench for bdp_port, modes A to D and an invalid mode.
   Assumes bdp_fifo_model on the FIFO side and bdp_chk bound. */
`timescale 1ns/10ps
`include "bdp_defs.vh"
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b0;
   logic dir = 1'b0;
   logic stall = 1'b0;
   logic [2:0] ck = 3'h0;
   logic [4:0] md = 5'h1f;
   logic [10:0] hw = 11'h0;
   wire [7:0] io_o, tx_d, rx_d, out_b;
   wire [2:0] fm_o, of, tx_f, rx_f;
   wire oe, oe_f, busy, avail, push, pop, full, rv;
   int fails = 0;
   int compares = 0;
   // Shared pins resolve to whoever drives them
   wire [7:0] io_w = oe ? io_o : hw[7:0];
   wire [2:0] fm_w = oe_f ? fm_o : hw[10:8];
   always #4 clk = ~clk;
   bdp_port u_dut (.i_mclk(clk), .i_resetn(rstn), .i_bulk_io_bus(io_w),
      .o_bulk_io_bus(io_o), .o_bulk_io_bus_oe(oe),
      .i_input_format_bus(fm_w), .o_input_format_bus(fm_o),
      .o_input_format_bus_oe(oe_f), .o_bulk_out_bus(out_b),
      .o_output_format_bus(of), .i_input_enable(en),
      .i_output_enable_dir_sel(dir), .o_input_busy(busy),
      .o_output_data_avail(avail), .i_input_port_clock(ck[0]),
      .i_output_port_clock(ck[1]), .i_half_rate_sys_clock(ck[2]),
      .i_input_mode_field(md[4:2]), .i_output_mode_field(md[1:0]),
      .o_tx_data(tx_d), .o_tx_fmt(tx_f), .o_tx_push(push),
      .i_tx_full(full), .i_rx_data(rx_d), .i_rx_fmt(rx_f),
      .i_rx_valid(rv), .i_rx_hold_loaded(rv), .o_rx_pop(pop));
   bdp_fifo_model u_fifo (.i_mclk(clk), .i_tx_data(tx_d), .i_tx_fmt(tx_f),
      .i_tx_push(push), .i_stall(stall), .o_tx_full(full), .o_rx_data(rx_d),
      .o_rx_fmt(rx_f), .o_rx_valid(rv), .i_rx_pop(pop));
   task automatic chk(input logic [10:0] e, s, input string n);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic drv(input logic e, d, input logic [10:0] w);
      @(posedge clk);
      en <= e;
      dir <= d;
      hw <= w;
   endtask
   // One port clock pulse, four system clocks plus 62.5 ns low then 62.5 ns high, off the system clock phase
   task automatic pulse(input int w);
      repeat (4) @(posedge clk);
      #62.5 ck[w] = 1'b1;
      #62.5 ck[w] = 1'b0;
   endtask
   task automatic setm(input logic [4:0] m);
      @(posedge clk);
      md <= m;
      repeat (12) @(posedge clk);
   endtask
   task automatic load(input logic [10:0] w);
      @(negedge clk);
      u_fifo.rxq.push_back(w);
      repeat (4) @(posedge clk);
   endtask
   task automatic t_a;
      int i;
      setm(5'h00);
      load({`BDP_FMT_START, 8'ha5});
      chk(1'b1, avail, "avail");
      drv(1'b1, 1'b0, {`BDP_FMT_START, 8'h3c});
      pulse(0);
      chk({`BDP_FMT_START, 8'h3c}, u_fifo.last_tx, "wr a");
      drv(1'b0, 1'b0, 11'h0);
      pulse(1);
      chk(0, u_fifo.npop, "gated");
      chk(`BDP_FMT_IDLE, of, "idle fmt");
      drv(1'b0, 1'b1, 11'h0);
      pulse(1);
      chk({`BDP_FMT_START, 8'ha5}, {of, out_b}, "rd a");
      for (i = 0; i < 3; i++)
      begin
         drv(1'b1, 1'b0, {`BDP_FMT_CONT, 8'h3c});
         pulse(0);
      end
      stall = 1'b1;
      drv(1'b0, 1'b0, 11'h0);
      pulse(0);
      chk(1'b1, busy, "busy a");
      drv(1'b1, 1'b0, 11'h0);
      pulse(0);
      chk(4, u_fifo.npush, "refused");
      stall = 1'b0;
      drv(1'b0, 1'b0, 11'h0);
      pulse(0);
      chk(0, busy, "busy off");
   endtask
   task automatic t_b;
      setm(5'h01);
      load({`BDP_FMT_CONT, 8'h77});
      pulse(1);
      chk({`BDP_FMT_CONT, 8'h77}, {of, out_b}, "rd b");
   endtask
   // Phase 0 falls on rises 0, 4, 8, 12; rise 8 lacks an idle gap
   task automatic t_c;
      int i;
      logic v;
      setm(5'h17);
      stall = 1'b1;
      load({`BDP_FMT_CONT, 8'h81});
      load({`BDP_FMT_CONT, 8'h82});
      for (i = 0; i <= 12; i++)
      begin
         v = (i == 0 || (i > 8 && i < 12)) ? 1'b0 : 1'b1;
         drv(v, v, {i == 12 ? 3'h4 : 3'h3, i[7:0]});
         // Host latches the earlier read as its enable rises
         if (i == 12)
            chk(8'h81, out_b, "latch c");
         pulse(2);
      end
      chk(6, u_fifo.npush, "pace w");
      chk({`BDP_FMT_START, 8'h0c}, u_fifo.last_tx, "cell");
      chk(4, u_fifo.npop, "pace r");
      chk(8'h82, out_b, "rd c");
      chk(0, busy, "no busy");
      stall = 1'b0;
   endtask
   task automatic t_d;
      setm(5'h04);
      load({`BDP_FMT_START, 8'h11});
      load({`BDP_FMT_CONT, 8'h22});
      drv(1'b1, 1'b1, 11'h0);
      repeat (5) @(posedge clk);
      chk(3'h7, {oe, oe_f, avail}, "oe d");
      pulse(1);
      chk({`BDP_FMT_START, 8'h11}, {fm_o, io_o}, "rd d");
      drv(1'b1, 1'b0, {`BDP_FMT_CONT, 8'h44});
      pulse(0);
      chk({`BDP_FMT_CONT, 8'h44}, u_fifo.last_tx, "wr d");
      stall = 1'b1;
      pulse(0);
      chk(1'b1, busy, "busy d");
      chk(7, u_fifo.npush, "held");
      drv(1'b1, 1'b1, 11'h0);
      pulse(1);
      chk({`BDP_FMT_CONT, 8'h22}, {fm_o, io_o}, "rd busy");
      load({`BDP_FMT_CONT, 8'h33});
      drv(1'b0, 1'b1, 11'h0);
      pulse(1);
      chk(6, {oe, oe_f, u_fifo.npop[8:0]}, "release");
      stall = 1'b0;
   endtask
   task automatic t_bad;
      setm(5'h1f);
      drv(1'b1, 1'b1, 11'h0);
      pulse(0);
      pulse(1);
      chk(7, u_fifo.npush, "bad w");
      chk(6, {avail, u_fifo.npop[9:0]}, "bad r");
   endtask
   task automatic close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk({3'h0, `BDP_FMT_IDLE}, {oe, busy, avail, of}, "reset");
      t_a();
      t_b();
      t_c();
      t_d();
      t_bad();
      close_out();
   end
   // Watchdog
   initial
   begin
      #200000;
      fails++;
      close_out();
   end
endmodule // tb
